// *** rtl/cpu_exception_sequencer.sv ***
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Simultaneous exceptions are taken one at a time by priority.
// RULE2: Reset first, then interrupts, then the software trap.
// RULE3: Trap is taken whenever executed in run state, ignoring masks; code drops a trap met at a boundary that lifts the block or takes an interrupt.
// RULE4: Reset handling starts right after the reset pin rises.
// RULE5: Interrupts are serviced only at instruction or exception boundary.
// RULE6: Interrupt and trap push program counter and flags first.
// RULE7: After stacking, the primary mask bit is set.
// RULE8: Vector address formed, handler address read, execution resumes there.
// RULE9: Reset skips stacking; only sets mask and fetches vector.
// RULE10: Reset 0, NMI 7, traps 8-11, external 12-17, internal 20-63.
// RULE11: Vectors 1-6, 18, 19 are reserved and never produced.
// RULE12: Vector address low 16 bits; four-byte or two-byte entries.
// RULE13: Accepts 27 internal sources plus the external ones.
// RULE14: While reset pin is low everything stops in reset state.
// RULE15: Reset initialises CPU state and peripheral registers.
// RULE16: Watchdog overflow also resets the chip.
// RULE17: Running reset must be held low at least 20 clocks.
// RULE18: Reset handling sets the primary mask bit.
// RULE19: Reset vector read at address zero, then jump there.
// RULE20: After reset every interrupt, NMI too, waits for first instruction.
// RULE21: The first instruction always runs right after reset ends.
// RULE22: Trap sets primary mask only if user mode select is one, else both.
// RULE23: Reset: vector fetch, internal step, then first instruction prefetch.
module cpu_exception_sequencer #(
  parameter int NUM_INT_SRC = exc_seq_pkg::NUM_INT,
  parameter int NUM_EXT_SRC = exc_seq_pkg::NUM_EXT
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic chip_reset_input_n,
  input wire logic watchdog_overflow,
  input wire logic nmi_request,
  input wire logic [NUM_EXT_SRC-1:0] external_request_lines,
  input wire logic [NUM_INT_SRC-1:0] internal_request_lines,
  input wire logic advanced_mode,
  input wire logic user_flag_mode_sel,
  input wire logic insn_boundary,
  input wire logic software_trap_op,
  input wire logic [1:0] trap_number,
  input wire logic [15:0] current_pc,
  input wire logic [15:0] stack_pointer,
  output logic cpu_halt,
  output logic periph_reset,
  output logic exc_busy,
  output logic [5:0] exc_vector,
  output logic load_pc,
  output logic [15:0] new_pc,
  output logic [7:0] condition_flags_reg,
  output logic first_insn_pending,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  // Internal sources must fit vectors 20 to 63; external sit at 12 to 17
  if (NUM_INT_SRC < 1 || NUM_INT_SRC > 44 ||
      NUM_EXT_SRC != 6) begin : g_bad_cfg
    $error("Source counts do not fit the vector table");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    S_RESET = 7'h01,
    S_VFETCH = 7'h02,
    S_INTERNAL = 7'h04,
    S_PREFETCH = 7'h08,
    S_RUN = 7'h10,
    S_PUSH_PC = 7'h20,
    S_PUSH_FLAGS = 7'h40
  } seq_state_t;

  typedef struct packed {
    seq_state_t fsm;
    logic pin_q;
    logic wdt_rst;
    logic [5:0] vec;
    logic is_trap;
    logic [15:0] sp;
    logic [15:0] pc_save;
    logic [7:0] flags;
    logic block_irq;
    logic issued;
    logic load;
    logic [15:0] target;
  } seq_reg_t;

  seq_reg_t st, next_st;
  exc_bus_if bus ();

  logic in_reset;
  logic [5:0] irq_vec;
  logic irq_any;
  logic irq_masked;

  // ------------------------------------------------------------
  // Interrupt ranking
  // ------------------------------------------------------------
  // Lowest vector wins; NMI is lowest numbered so it ranks first.
  always_comb begin
    irq_any = 1'b0;
    irq_vec = exc_seq_pkg::VEC_NMI;
    for (int i = NUM_INT_SRC - 1; i >= 0; i--) begin
      if (internal_request_lines[i] && !irq_masked) begin
        irq_any = 1'b1; // RULE13
        irq_vec = exc_seq_pkg::VEC_INT_BASE + 6'(i);
      end
    end
    for (int i = NUM_EXT_SRC - 1; i >= 0; i--) begin
      if (external_request_lines[i] && !irq_masked) begin
        irq_any = 1'b1;
        irq_vec = exc_seq_pkg::VEC_EXT_BASE + 6'(i); // RULE10
      end
    end
    if (nmi_request) begin
      irq_any = 1'b1;
      irq_vec = exc_seq_pkg::VEC_NMI;
    end
  end

  // Pin low or watchdog holds the whole chip stopped
  assign in_reset = !chip_reset_input_n || st.wdt_rst; // RULE14 RULE16

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_q = chip_reset_input_n;
    next_st.load = 1'b0;
    bus.rd_req = 1'b0;
    bus.wr_req = 1'b0;
    bus.addr = '0;
    bus.wdata = '0;
    // Watchdog reset lasts one cycle past the overflow, ending before the vector fetch starts
    if (watchdog_overflow) begin
      next_st.wdt_rst = 1'b1; // RULE16
    end
    if (in_reset) begin
      next_st.fsm = S_RESET; // RULE14 RULE15
      next_st.flags = exc_seq_pkg::FLAGS_RESET; // RULE18
      next_st.vec = exc_seq_pkg::VEC_RESET;
      next_st.block_irq = 1'b1;
      next_st.issued = 1'b0;
      next_st.is_trap = 1'b0;
      // Watchdog hold ends after one cycle; a fresh overflow wins
      if (!watchdog_overflow) begin
        next_st.wdt_rst = 1'b0; // RULE16
      end
    end else begin
      unique case (st.fsm)
        S_RESET: begin
          // Leaving reset: no stacking for this exception
          next_st.wdt_rst = 1'b0;
          next_st.fsm = S_VFETCH; // RULE4 RULE9
          next_st.vec = exc_seq_pkg::VEC_RESET; // RULE19
          next_st.issued = 1'b0;
        end
        S_VFETCH: begin
          if (!st.issued) begin
            bus.rd_req = 1'b1; // RULE8 RULE12
            bus.addr = advanced_mode ?
              16'({st.vec, 2'b00}) : 16'({st.vec, 1'b0});
            next_st.issued = 1'b1;
          end else if (bus.done) begin
            next_st.target = bus.rdata;
            next_st.issued = 1'b0;
            next_st.fsm = S_INTERNAL; // RULE23
          end
        end
        S_INTERNAL: begin
          next_st.load = 1'b1; // RULE8
          next_st.fsm = S_PREFETCH;
        end
        S_PREFETCH: begin
          if (!st.issued) begin
            bus.rd_req = 1'b1; // RULE23
            bus.addr = st.target;
            next_st.issued = 1'b1;
          end else if (bus.done) begin
            next_st.issued = 1'b0;
            next_st.fsm = S_RUN;
          end
        end
        S_RUN: begin
          // Block lifts once the first instruction completes
          if (insn_boundary && st.block_irq) begin
            next_st.block_irq = 1'b0; // RULE20 RULE21
          end else if (insn_boundary && irq_any && !st.block_irq) begin
            next_st.vec = irq_vec; // RULE1 RULE2 RULE5
            next_st.is_trap = 1'b0;
            next_st.sp = stack_pointer;
            next_st.pc_save = current_pc;
            next_st.fsm = S_PUSH_PC; // RULE6
          end else if (software_trap_op) begin
            next_st.vec = exc_seq_pkg::VEC_TRAP_BASE + 6'(trap_number);
            next_st.is_trap = 1'b1; // RULE3
            next_st.sp = stack_pointer;
            next_st.pc_save = current_pc;
            next_st.block_irq = 1'b0;
            next_st.fsm = S_PUSH_PC; // RULE6
          end
        end
        S_PUSH_PC: begin
          if (!st.issued) begin
            bus.wr_req = 1'b1; // RULE6
            bus.addr = st.sp - 16'h0002;
            bus.wdata = st.pc_save;
            next_st.issued = 1'b1;
          end else if (bus.done) begin
            next_st.sp = st.sp - 16'h0002;
            next_st.issued = 1'b0;
            next_st.fsm = S_PUSH_FLAGS;
          end
        end
        S_PUSH_FLAGS: begin
          if (!st.issued) begin
            bus.wr_req = 1'b1;
            bus.addr = st.sp - 16'h0002;
            bus.wdata = {st.flags, st.flags};
            next_st.issued = 1'b1;
          end else if (bus.done) begin
            next_st.sp = st.sp - 16'h0002;
            next_st.issued = 1'b0;
            next_st.flags[exc_seq_pkg::FLAG_MASK_POS] = 1'b1; // RULE7
            if (st.is_trap && !user_flag_mode_sel) begin
              next_st.flags[exc_seq_pkg::FLAG_SEC_POS] = 1'b1; // RULE22
            end
            next_st.fsm = S_VFETCH; // RULE8
          end
        end
        default: begin
          next_st.fsm = S_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{fsm: S_RESET, flags: exc_seq_pkg::FLAGS_RESET,
              block_irq: 1'b1, pin_q: 1'b0, default: '0};
    end else begin
      st <= next_st;
    end
  end

  exc_bus_port u_port (
    .clk_sys(clk_sys),
    // Reset also drops a half-done bus cycle, so no stale answer survives
    .srst(srst || in_reset),
    .bus(bus),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  assign irq_masked = st.flags[exc_seq_pkg::FLAG_MASK_POS];
  assign cpu_halt = st.fsm != S_RUN;
  assign periph_reset = in_reset; // RULE15
  assign exc_busy = st.fsm != S_RUN && st.fsm != S_RESET;
  assign exc_vector = st.vec;
  assign load_pc = st.load;
  assign new_pc = st.target;
  assign condition_flags_reg = st.flags;
  assign first_insn_pending = st.block_irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence reset_release;
    !st.pin_q ##1 chip_reset_input_n && !st.wdt_rst;
  endsequence

  // Last stack word acknowledged with no reset in the way
  sequence stack_done;
    st.fsm == S_PUSH_FLAGS && bus.done && !in_reset;
  endsequence

  a_reset_starts_fetch: assert property ( // RULE4
    reset_release |=> st.fsm == S_VFETCH)
    else $error("Reset release did not start vector fetch");
  a_reset_no_stack: assert property ( // RULE9
    st.fsm == S_RESET |-> !mem_wr)
    else $error("Stack write during reset");
  a_reset_mask_set: assert property ( // RULE18
    st.fsm == S_VFETCH && st.vec == 6'h00 |->
      st.flags[exc_seq_pkg::FLAG_MASK_POS])
    else $error("Mask clear in reset vector fetch");
  a_reset_vec_addr: assert property ( // RULE19
    bus.rd_req && st.fsm == S_VFETCH && st.vec == 6'h00 |->
      bus.addr == 16'h0000)
    else $error("Reset vector not read at zero");
  a_held_in_reset: assert property ( // RULE14
    !chip_reset_input_n |=> st.fsm == S_RESET && cpu_halt)
    else $error("Not held in reset while pin low");
  a_wdt_resets: assert property ( // RULE16
    watchdog_overflow && chip_reset_input_n |=> periph_reset)
    else $error("Watchdog overflow did not reset");
  a_irq_blocked: assert property ( // RULE20
    st.fsm == S_RUN && st.block_irq && !software_trap_op && !in_reset |=>
      st.fsm == S_RUN)
    else $error("Interrupt taken before first instruction");
  a_trap_taken: assert property ( // RULE3
    st.fsm == S_RUN && software_trap_op && chip_reset_input_n &&
      !st.wdt_rst && !watchdog_overflow &&
      !(insn_boundary && (st.block_irq || irq_any)) |=>
      st.fsm == S_PUSH_PC && st.vec == 6'h08 + 6'($past(trap_number)))
    else $error("Trap not taken");
  a_push_order: assert property ( // RULE7
    stack_done |=> st.fsm == S_VFETCH &&
      st.flags[exc_seq_pkg::FLAG_MASK_POS])
    else $error("Mask not set after stacking");
  a_trap_sec_mask: assert property ( // RULE22
    stack_done ##0 (st.is_trap && !user_flag_mode_sel) |=>
      st.flags[exc_seq_pkg::FLAG_SEC_POS])
    else $error("Secondary mask not set by trap");
  a_stack_first: assert property ( // RULE6
    st.fsm == S_RUN ##1 st.fsm != S_RUN |->
      st.fsm == S_PUSH_PC || st.fsm == S_RESET)
    else $error("Exception entered without stacking");
  a_load_after_fetch: assert property ( // RULE8
    st.fsm == S_INTERNAL && !in_reset |=>
      load_pc && st.fsm == S_PREFETCH)
    else $error("Start address not loaded after fetch");
  a_prefetch_run: assert property ( // RULE23
    st.fsm == S_PREFETCH && bus.done && !in_reset |=> st.fsm == S_RUN)
    else $error("Prefetch did not hand over to run state");
  a_no_reserved_vec: assert property ( // RULE11
    !(st.vec inside {[6'h01:6'h06], 6'h12, 6'h13}))
    else $error("Reserved vector produced");
  a_int_priority: assert property ( // RULE2
    nmi_request |-> irq_vec == exc_seq_pkg::VEC_NMI)
    else $error("NMI not ranked first");
endmodule

// *** rtl/exc_bus_if.sv ***
`timescale 1ns/1ps
// Vector and stack traffic between sequencer and the bus port
interface exc_bus_if;
  logic rd_req;
  logic wr_req;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport seq (output rd_req, wr_req, addr, wdata, input rdata, done);
  modport port (input rd_req, wr_req, addr, wdata, output rdata, done);
endinterface

// *** rtl/exc_bus_port.sv ***
`timescale 1ns/1ps
// Registers one request onto the memory bus and returns its answer
module exc_bus_port (
  input wire logic clk_sys,
  input wire logic srst,
  exc_bus_if.port bus,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
  } port_state_t;
  port_state_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (st.rd || st.wr) begin
      if (mem_ack) begin
        next_st.rd = 1'b0;
        next_st.wr = 1'b0;
        next_st.rdata = mem_rdata;
        next_st.done = 1'b1;
      end
    end else if (bus.rd_req || bus.wr_req) begin
      next_st.rd = bus.rd_req;
      next_st.wr = bus.wr_req;
      next_st.addr = bus.addr;
      next_st.wdata = bus.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mem_rd = st.rd;
  assign mem_wr = st.wr;
  assign mem_addr = st.addr;
  assign mem_wdata = st.wdata;
  assign bus.rdata = st.rdata;
  assign bus.done = st.done;
endmodule

// *** rtl/exc_seq_pkg.sv ***
package exc_seq_pkg;
  // Vector numbers
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [5:0] VEC_EXT_BASE = 6'h0c;
  localparam logic [5:0] VEC_INT_BASE = 6'h14;
  localparam logic [5:0] VEC_LAST = 6'h3f;
  localparam int NUM_EXT = 6;
  localparam int NUM_INT = 27;
  localparam int NUM_TRAP = 4;
  // Flags register bit positions and reset value
  localparam int FLAG_MASK_POS = 7;
  localparam int FLAG_SEC_POS = 6;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  // Vector address shifts: four-byte entries in advanced, two in normal
  localparam int SHIFT_ADV = 2;
  localparam int SHIFT_NRM = 1;
  localparam int ADDR_W = 16;
  // Least reset hold while running, in system clocks
  localparam int RESET_HOLD_CYC = 20;
endpackage

// *** verif/mem_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Word memory answering the vector and stack traffic
// ----------------------------------------
// The wait count lets a scenario pick a prompt or a slow answer.
// Between answers the read data is junk that settles at 16'hffff from the sixth clock on, so a design that
// samples outside its acknowledged cycle picks up that fixed junk.
module mem_model (
  input wire logic clk_sys,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] wait_cyc,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:511];
  logic [1:0] cnt;
  logic [15:0] junk;

  initial begin
    cnt = 2'h0;
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    junk = 16'h5a5a;
    foreach (mem[i]) mem[i] = 16'(i);
  end

  always @(posedge clk_sys) begin
    junk <= ~junk ^ {junk[14:0], junk[15]};
    mem_ack <= 1'b0;
    mem_rdata <= junk;
    if ((mem_rd || mem_wr) && !mem_ack) begin
      if (cnt == wait_cyc) begin
        mem_ack <= 1'b1;
        cnt <= 2'h0;
        if (mem_rd) mem_rdata <= mem[mem_addr[9:1]];
        if (mem_wr) mem[mem_addr[9:1]] <= mem_wdata;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clk_sys, srst, pin_n, wdog, nmi, adv, ue, bnd, trap;
  logic cpu_halt, periph_reset, exc_busy, load_pc, first_insn_pending;
  logic mem_rd, mem_wr, mem_ack;
  logic [5:0] ext, exc_vector;
  logic [26:0] intl;
  logic [1:0] tnum, wait_cyc;
  logic [15:0] pc, sp, new_pc, mem_addr, mem_wdata, mem_rdata;
  logic [7:0] condition_flags_reg, flags, sf;
  logic [32:0] log_q[$], exp_q[$];
  logic [31:0] rs;
  int err_total, n_tests, cyc;

  cpu_exception_sequencer i_dut (.clk_sys(clk_sys), .srst(srst),
    .chip_reset_input_n(pin_n), .watchdog_overflow(wdog),
    .nmi_request(nmi), .external_request_lines(ext),
    .internal_request_lines(intl), .advanced_mode(adv),
    .user_flag_mode_sel(ue), .insn_boundary(bnd),
    .software_trap_op(trap), .trap_number(tnum), .current_pc(pc),
    .stack_pointer(sp), .cpu_halt(cpu_halt), .periph_reset(periph_reset),
    .exc_busy(exc_busy), .exc_vector(exc_vector), .load_pc(load_pc),
    .new_pc(new_pc), .condition_flags_reg(condition_flags_reg),
    .first_insn_pending(first_insn_pending), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  mem_model i_mem (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cyc(wait_cyc),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Every acknowledged bus cycle is logged for the sequence comparison
  always @(posedge clk_sys) begin
    if (mem_ack === 1'b1 && (mem_rd || mem_wr))
      log_q.push_back({mem_wr, mem_addr, mem_wr ? mem_wdata : 16'h0});
  end

  function automatic logic [15:0] vaddr(input logic [5:0] v);
    return adv ? {8'h0, v, 2'b00} : {9'h0, v, 1'b0};
  endfunction

  // Plants an even handler address in the vector entry, clears the log
  task automatic prep(input logic [5:0] v);
    logic [31:0] r;
    r = rnd();
    i_mem.mem[vaddr(v) >> 1] = {6'h0, 1'b1, r[8:1], 1'b0};
    log_q = {};
  endtask

  task automatic expect_exc(input logic [5:0] v, input logic stk,
                            input logic [15:0] spc, input logic [7:0] f);
    logic [15:0] va, tgt;
    int n;
    va = vaddr(v);
    tgt = i_mem.mem[va >> 1];
    exp_q = {};
    if (stk) begin
      exp_q.push_back({1'b1, sp - 16'h2, spc});
      exp_q.push_back({1'b1, sp - 16'h4, f, f});
    end
    exp_q.push_back({1'b0, va, 16'h0});
    exp_q.push_back({1'b0, tgt, 16'h0});
    n = 0;
    while (load_pc !== 1'b1 && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk(33'(load_pc), 33'h1, "no load_pc");
    chk(33'(new_pc), 33'(tgt), "new_pc");
    chk(33'(exc_vector), 33'(v), "vector");
    n = 0;
    while (cpu_halt !== 1'b0 && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk(33'(condition_flags_reg), 33'(flags), "flags");
    chk(33'(log_q.size()), 33'(exp_q.size()), "bus count");
    foreach (exp_q[k]) begin
      if (k < log_q.size()) chk(log_q[k], exp_q[k], "bus cycle");
    end
  endtask

  task automatic pin_reset();
    @(posedge clk_sys);
    pin_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(33'(cpu_halt), 33'h1, "halt in reset");
    chk(33'(periph_reset), 33'h1, "periph reset");
    prep(6'h0);
    flags = 8'h80;
    @(posedge clk_sys);
    pin_n <= 1'b1;
    expect_exc(6'h0, 1'b0, 16'h0, 8'h0);
    chk(33'(first_insn_pending), 33'h1, "block after reset");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rs = 32'h14d9;
    err_total = 0;
    n_tests = 0;
    flags = 8'h80;
    {srst, pin_n, wdog, nmi, adv, ue, bnd, trap} = 8'b1000_1100;
    ext = 6'h0;
    intl = 27'h0;
    tnum = 2'h0;
    wait_cyc = 2'h1;
    pc = 16'h1234;
    sp = 16'h01c0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    pin_reset();
    // A request before the first instruction must wait
    @(posedge clk_sys);
    nmi <= 1'b1;
    repeat (6) begin
      @(negedge clk_sys);
      chk(33'(exc_busy), 33'h0, "early accept");
    end
    @(posedge clk_sys);
    bnd <= 1'b1;
    @(posedge clk_sys);
    {nmi, bnd} <= 2'b00;
    @(negedge clk_sys);
    chk(33'(first_insn_pending), 33'h0, "block kept");
    @(posedge clk_sys);
    // Maskable requests stay refused while the mask bit is set
    ext <= 6'(rnd()) | 6'h1;
    intl <= 27'(rnd()) | 27'h1;
    bnd <= 1'b1;
    repeat (4) begin
      @(negedge clk_sys);
      chk(33'(exc_busy), 33'h0, "masked taken");
    end
    @(posedge clk_sys);
    {ext, intl, bnd} <= 34'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      adv <= i[0];
      ue <= i[2];
      wait_cyc <= 2'(rnd());
      pc <= 16'(rnd()) & 16'hfffe;
      @(negedge clk_sys);
      prep(6'h7);
      // Upper half: a trap coincides with the boundary and loses
      @(posedge clk_sys);
      nmi <= 1'b1;
      bnd <= 1'b1;
      trap <= (i > 3);
      tnum <= i[1:0];
      @(posedge clk_sys);
      {nmi, bnd, trap} <= 3'b000;
      sf = flags;
      flags = flags | 8'h80;
      expect_exc(6'h7, 1'b1, pc, sf);
      prep(6'h8 + 6'(i[1:0]));
      @(posedge clk_sys);
      trap <= 1'b1;
      @(posedge clk_sys);
      trap <= 1'b0;
      sf = flags;
      flags = flags | (ue ? 8'h80 : 8'hc0);
      expect_exc(6'h8 + 6'(i[1:0]), 1'b1, pc, sf);
    end
    // Watchdog overflow restarts through the reset vector
    prep(6'h0);
    flags = 8'h80;
    @(posedge clk_sys);
    wdog <= 1'b1;
    @(posedge clk_sys);
    wdog <= 1'b0;
    expect_exc(6'h0, 1'b0, 16'h0, 8'h0);
    // Last reset runs in normal mode with two-byte entries
    @(posedge clk_sys);
    adv <= 1'b0;
    pin_reset();
    close_out();
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc == 20000) begin
        err_total++;
        close_out();
      end
    end
  end
endmodule
